// [rtl/mpd_pkg.sv]
// package: constants and carrier types for the region permission decoder
package mpd_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BUS_AW = 4;

    // register byte offsets
    localparam logic [BUS_AW-1:0] OFS_ATTR   = 4'h0;
    localparam logic [BUS_AW-1:0] OFS_FSTAT  = 4'h4;
    localparam logic [BUS_AW-1:0] OFS_FADDR  = 4'h8;
    localparam logic [BUS_AW-1:0] OFS_DECODE = 4'hC;

    // region_attribute_size_reg field positions
    localparam int ATTR_XN_POS  = 28;
    localparam int ATTR_AP_LSB  = 24;
    localparam int ATTR_TEX_LSB = 19;
    localparam int ATTR_S_POS   = 18;
    localparam int ATTR_C_POS   = 17;
    localparam int ATTR_B_POS   = 16;
    localparam logic [DATA_W-1:0] ATTR_MASK  = 32'h173F_0000;
    localparam logic [DATA_W-1:0] ATTR_RESET = 32'h0000_0000;

    // memory_fault_status_reg bits, write one to clear
    localparam int FS_IACC_POS = 0;
    localparam int FS_DACC_POS = 1;
    localparam int FS_W        = 2;
    localparam logic [FS_W-1:0]   FS_RESET    = 2'h0;
    localparam logic [DATA_W-1:0] FADDR_RESET = 32'h0000_0000;

    // access permission codes
    localparam logic [2:0] AP_NONE    = 3'h0;
    localparam logic [2:0] AP_PRIV_RW = 3'h1;
    localparam logic [2:0] AP_USER_RO = 3'h2;
    localparam logic [2:0] AP_FULL    = 3'h3;
    localparam logic [2:0] AP_RSVD    = 3'h4;
    localparam logic [2:0] AP_PRIV_RO = 3'h5;
    localparam logic [2:0] AP_RO_A    = 3'h6;
    localparam logic [2:0] AP_RO_B    = 3'h7;

    // cache policy codes
    localparam logic [1:0] POL_NC     = 2'h0;
    localparam logic [1:0] POL_WB_WA  = 2'h1;
    localparam logic [1:0] POL_WT     = 2'h2;
    localparam logic [1:0] POL_WB_NWA = 2'h3;

    typedef enum logic [1:0] {
        MPD_MT_SO,
        MPD_MT_DEV,
        MPD_MT_NORMAL
    } mpd_mem_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              priv;
        logic              fetch;
    } mpd_req_t;

    typedef struct packed {
        logic     rsvd;
        logic [1:0] outer_cache_policy;
        logic [1:0] inner_cache_policy;
        logic     shareable;
        mpd_mem_t mem_type;
    } mpd_dec_t;

endpackage

// [rtl/mpd_top.sv]
// region permission check and memory attribute decode with AHB-Lite regs
`timescale 1ns/100ps

module mpd_top
    import mpd_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire logic              hsel_i,
    input  wire logic [ADDR_W-1:0] haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [DATA_W-1:0] hwdata_i,
    input  wire logic              hready_i,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    output logic      [DATA_W-1:0] hrdata_o,
    input  wire logic              req_valid_i,
    input  wire mpd_req_t          req_i,
    output logic                   resp_valid_o,
    output logic                   resp_fault_o,
    output logic                   mm_fault_o,
    output mpd_dec_t               attr_o
);

    logic [DATA_W-1:0] attr_reg;
    logic [FS_W-1:0]   fstat_reg;
    logic [FS_W-1:0]   fstat_next;
    logic [DATA_W-1:0] faddr_reg;
    logic              wr_pend_reg;
    logic [BUS_AW-1:0] wr_addr_reg;
    logic              resp_fetch_reg;
    logic [2:0]        ap;
    logic              allowed;
    logic              fault_now;
    mpd_dec_t          dec;
    logic              rd_take;
    logic [DATA_W-1:0] rd_data;

    // attribute decode, reserved codes fall to strongly ordered
    function automatic mpd_dec_t decode_attr(input logic [2:0] type_extension_field,
                                             input logic       s,
                                             input logic       c,
                                             input logic       b);
        mpd_dec_t d;
        d.mem_type           = MPD_MT_SO;
        d.shareable          = 1'b1;
        d.inner_cache_policy = POL_NC;
        d.outer_cache_policy = POL_NC;
        d.rsvd               = 1'b0;
        if (type_extension_field[2]) begin
            d.mem_type           = MPD_MT_NORMAL;
            d.shareable          = s;
            d.inner_cache_policy = {c, b};
            d.outer_cache_policy = type_extension_field[1:0];
        end else begin
            case (type_extension_field[1:0])
                2'b00: begin
                    if (!c) begin
                        d.mem_type = b ? MPD_MT_DEV : MPD_MT_SO;
                    end else begin
                        d.mem_type           = MPD_MT_NORMAL;
                        d.shareable          = s;
                        d.inner_cache_policy = POL_WT;
                        d.outer_cache_policy = POL_WT;
                    end
                end
                2'b01: begin
                    if (c == b) begin
                        d.mem_type           = MPD_MT_NORMAL;
                        d.shareable          = s;
                        d.inner_cache_policy = c ? POL_WB_WA : POL_NC;
                        d.outer_cache_policy = c ? POL_WB_WA : POL_NC;
                    end else begin
                        d.rsvd = 1'b1;
                    end
                end
                2'b10: begin
                    if (!c && !b) begin
                        d.mem_type  = MPD_MT_DEV;
                        d.shareable = 1'b0;
                    end else begin
                        d.rsvd = 1'b1;
                    end
                end
                default: begin
                    d.rsvd = 1'b1;
                end
            endcase
        end
        return d;
    endfunction

    assign dec = decode_attr(attr_reg[ATTR_TEX_LSB +: 3],
                             attr_reg[ATTR_S_POS],
                             attr_reg[ATTR_C_POS],
                             attr_reg[ATTR_B_POS]);
    assign ap  = attr_reg[ATTR_AP_LSB +: 3];

    // permission table; the decoded attributes never enter here
    always_comb begin
        case (ap)
            AP_NONE:    allowed = 1'b0;
            AP_PRIV_RW: allowed = req_i.priv;
            AP_USER_RO: allowed = req_i.priv || !req_i.write;
            AP_FULL:    allowed = 1'b1;
            AP_PRIV_RO: allowed = req_i.priv && !req_i.write;
            AP_RO_A,
            AP_RO_B:    allowed = !req_i.write;
            default:    allowed = 1'b0;
        endcase
    end

    assign fault_now = req_valid_i &&
        (!allowed || (req_i.fetch && attr_reg[ATTR_XN_POS]));

    // registered decision, one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            resp_valid_o   <= 1'b0;
            resp_fault_o   <= 1'b0;
            mm_fault_o     <= 1'b0;
            resp_fetch_reg <= 1'b0;
        end else begin
            resp_valid_o   <= req_valid_i;
            resp_fault_o   <= fault_now;
            mm_fault_o     <= fault_now;
            resp_fetch_reg <= req_i.fetch;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            attr_o <= '0;
        end else begin
            attr_o <= dec;
        end
    end

    // fault cause, set wins over a write-one clear
    always_comb begin
        fstat_next = fstat_reg;
        if (wr_pend_reg && wr_addr_reg == OFS_FSTAT) begin
            fstat_next = fstat_reg & ~hwdata_i[FS_W-1:0];
        end
        if (fault_now) begin
            fstat_next[FS_IACC_POS] = fstat_next[FS_IACC_POS] |
                                      req_i.fetch;
            fstat_next[FS_DACC_POS] = fstat_next[FS_DACC_POS] |
                                      !req_i.fetch;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            fstat_reg <= FS_RESET;
        end else begin
            fstat_reg <= fstat_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            faddr_reg <= FADDR_RESET;
        end else if (fault_now) begin
            faddr_reg <= req_i.addr;
        end else if (wr_pend_reg && wr_addr_reg == OFS_FADDR) begin
            faddr_reg <= hwdata_i;
        end
    end

    // bus slave: zero wait states, always OKAY
    assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;

    always_comb begin
        case (haddr_i[BUS_AW-1:0])
            OFS_ATTR:   rd_data = attr_reg;
            OFS_FSTAT:  rd_data = {{(DATA_W-FS_W){1'b0}}, fstat_reg};
            OFS_FADDR:  rd_data = faddr_reg;
            OFS_DECODE: rd_data = {{(DATA_W-8){1'b0}}, dec};
            default:    rd_data = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (hready_i) begin
            wr_pend_reg <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr_reg <= haddr_i[BUS_AW-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hrdata_o <= '0;
        end else if (rd_take) begin
            hrdata_o <= (haddr_i[ADDR_W-1:BUS_AW] == '0) ? rd_data : '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            attr_reg <= ATTR_RESET;
        end else if (wr_pend_reg && wr_addr_reg == OFS_ATTR) begin
            attr_reg <= hwdata_i & ATTR_MASK;
        end
    end

    // checks
    ap_none_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap == AP_NONE |=> resp_valid_o && resp_fault_o)
        else $error("permission 000 access not faulted");
    ap_priv_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap == AP_PRIV_RW && !req_i.fetch
        |=> resp_fault_o == !$past(req_i.priv))
        else $error("permission 001 decision wrong");
    ap_userro_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap == AP_USER_RO && !req_i.fetch
        |=> resp_fault_o == ($past(req_i.write) && !$past(req_i.priv)))
        else $error("permission 010 decision wrong");
    ap_full_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap == AP_FULL && !req_i.fetch |=> !resp_fault_o)
        else $error("permission 011 access faulted");
    ap_privro_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap == AP_PRIV_RO && !req_i.fetch
        |=> resp_fault_o == ($past(req_i.write) || !$past(req_i.priv)))
        else $error("permission 101 decision wrong");
    ap_ro_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && ap[2:1] == 2'b11 && !req_i.fetch
        |=> resp_fault_o == $past(req_i.write))
        else $error("read-only permission decision wrong");
    xn_fetch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && req_i.fetch && attr_reg[ATTR_XN_POS]
        |=> resp_fault_o && fstat_reg[FS_IACC_POS])
        else $error("execute-never fetch not faulted");
    fault_rec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        resp_fault_o |-> mm_fault_o &&
            fstat_reg[resp_fetch_reg ? FS_IACC_POS : FS_DACC_POS])
        else $error("fault cause not recorded");
    resp_time_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        resp_fault_o |-> resp_valid_o && $past(req_valid_i))
        else $error("fault without request one cycle earlier");
    dev_dec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        attr_reg[ATTR_TEX_LSB +: 3] == 3'h0 && !attr_reg[ATTR_C_POS]
        |=> attr_o.shareable && attr_o.mem_type ==
            ($past(attr_reg[ATTR_B_POS]) ? MPD_MT_DEV : MPD_MT_SO))
        else $error("type 000 uncached decode wrong");

    fault_user_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i && !req_i.priv && req_i.write ##1 resp_fault_o);
    pass_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        req_valid_i ##1 resp_valid_o && !resp_fault_o);
    set_clr_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        fault_now && wr_pend_reg && wr_addr_reg == OFS_FSTAT);

endmodule

// [tb/mpd_core_model.sv]
// core-side model: issues load, store and fetch requests to the decoder
`timescale 1ns/100ps
module mpd_core_model
    import mpd_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic resp_valid_i,
    input  wire logic resp_fault_i,
    input  wire logic mm_fault_i,
    output logic      req_valid_o,
    output mpd_req_t  req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // one request; the answer is sampled once the next edge has landed
    task automatic access(input logic wr,
                          input logic pr,
                          input logic fe,
                          input logic [ADDR_W-1:0] a,
                          output logic [2:0] r);
        req_valid_o <= 1'b1;
        req_o       <= '{a, wr, pr, fe};
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        // idle request lines never keep the last value
        req_o       <= ~{a, wr, pr, fe};
        #1;
        r = {resp_valid_i, resp_fault_i, mm_fault_i};
        @(posedge clk_sys_i);
    endtask
endmodule

// [tb/mpd_top_test.sv]
// testbench for the region permission decoder
`timescale 1ns/100ps
module mpd_top_test
    import mpd_pkg::*;
;
    logic              clk_sys_i = 1'b0;
    logic              reset_i   = 1'b1;
    logic              hsel      = 1'b0;
    logic [ADDR_W-1:0] haddr     = '0;
    logic [1:0]        htrans    = 2'h0;
    logic              hwrite    = 1'b0;
    logic [DATA_W-1:0] hwdata    = '0;
    logic              hready;
    logic [DATA_W-1:0] hrdata;
    logic              req_valid;
    mpd_req_t          req;
    logic              resp_valid;
    logic              resp_fault;
    logic              mm_fault;
    mpd_dec_t          attr;
    int                mismatches = 0;
    int                num_checks = 0;
    int                cyc        = 0;
    logic [DATA_W-1:0] q;
    logic [2:0]        r;
    // {2'h0, tex, s, c, b}, expected decode, compare mask
    localparam logic [23:0] ATTR_TBL [13] = '{
        24'h000487, 24'h040487, 24'h050587, 24'h0252FF, 24'h0656FF,
        24'h0756FF, 24'h0802FF, 24'h0F2EFF, 24'h0984FF, 24'h354EFF,
        24'h2B3AFF, 24'h100187, 24'h1284FF};

    always #25 clk_sys_i = ~clk_sys_i;

    mpd_top mpd_top_i (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .hsel_i      (hsel),
        .haddr_i     (haddr),
        .htrans_i    (htrans),
        .hwrite_i    (hwrite),
        .hsize_i     (3'h2),
        .hwdata_i    (hwdata),
        .hready_i    (hready),
        .hreadyout_o (hready),
        .hresp_o     (),
        .hrdata_o    (hrdata),
        .req_valid_i (req_valid),
        .req_i       (req),
        .resp_valid_o(resp_valid),
        .resp_fault_o(resp_fault),
        .mm_fault_o  (mm_fault),
        .attr_o      (attr)
    );

    mpd_core_model mpd_core_model_i (
        .clk_sys_i   (clk_sys_i),
        .resp_valid_i(resp_valid),
        .resp_fault_i(resp_fault),
        .mm_fault_i  (mm_fault),
        .req_valid_o (req_valid),
        .req_o       (req)
    );

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // single AHB-Lite word transfer; read data lands in q
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [DATA_W-1:0] d);
        hsel   <= 1'b1;
        haddr  <= ADDR_W'(a);
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic set_attr(input logic xn, input logic [2:0] ap,
                            input logic [5:0] aa);
        bus(1'b1, OFS_ATTR, {3'h0, xn, 1'h0, ap, 2'h0, aa, 16'h0});
    endtask

    function automatic logic allowed(logic [2:0] ap, logic pr, logic wr);
        case (ap)
            3'h1: allowed = pr;
            3'h2: allowed = pr | !wr;
            3'h3: allowed = 1'b1;
            3'h5: allowed = pr & !wr;
            3'h6, 3'h7: allowed = !wr;
            default: allowed = 1'b0;
        endcase
    endfunction

    task automatic t_reset();
        bus(1'b0, OFS_ATTR, '0);
        chk("attr reg", ATTR_RESET, q);
        bus(1'b0, OFS_FSTAT, '0);
        chk("fault status", 32'h0, q);
        mpd_core_model_i.access(1'b0, 1'b1, 1'b0, 32'h0000_0100, r);
        chk("reset access", 32'h7, 32'(r));
    endtask

    task automatic t_perm();
        logic ok;
        for (int ap = 0; ap < 8; ap++) begin
            set_attr(1'b0, 3'(ap), 6'h06);
            for (int k = 0; k < 4; k++) begin
                ok = allowed(3'(ap), k[1], k[0]);
                mpd_core_model_i.access(k[0], k[1], 1'b0, 32'h40, r);
                chk("perm", {29'h1, !ok, !ok}, 32'(r));
            end
        end
        mpd_core_model_i.access(1'b0, 1'b0, 1'b1, 32'h44, r);
        chk("ro fetch", 32'h4, 32'(r));
    endtask

    task automatic t_fstat();
        bus(1'b1, OFS_FSTAT, 32'h3);
        set_attr(1'b0, 3'h0, 6'h06);
        mpd_core_model_i.access(1'b1, 1'b1, 1'b0, 32'h2000_0010, r);
        bus(1'b0, OFS_FSTAT, '0);
        chk("data fault", 32'h2, q);
        bus(1'b0, OFS_FADDR, '0);
        chk("fault addr", 32'h2000_0010, q);
        set_attr(1'b1, 3'h3, 6'h06);
        mpd_core_model_i.access(1'b0, 1'b1, 1'b0, 32'h500, r);
        chk("xn data", 32'h4, 32'(r));
        mpd_core_model_i.access(1'b0, 1'b1, 1'b1, 32'h400, r);
        chk("xn fetch", 32'h7, 32'(r));
        bus(1'b0, OFS_FSTAT, '0);
        chk("both faults", 32'h3, q);
        bus(1'b0, OFS_FADDR, '0);
        chk("fetch addr", 32'h400, q);
        bus(1'b1, OFS_FSTAT, 32'h1);
        bus(1'b0, OFS_FSTAT, '0);
        chk("clear fetch", 32'h2, q);
        bus(1'b1, OFS_FSTAT, 32'h2);
        bus(1'b0, OFS_FSTAT, '0);
        chk("clear data", 32'h0, q);
    endtask

    task automatic t_attr();
        logic [7:0] e;
        logic [7:0] m;
        for (int i = 0; i < 13; i++) begin
            e = ATTR_TBL[i][15:8];
            m = ATTR_TBL[i][7:0];
            set_attr(1'b0, 3'h3, ATTR_TBL[i][21:16]);
            bus(1'b0, OFS_DECODE, '0);
            chk("decode reg", 32'(e & m), 32'(q[7:0] & m));
            chk("attr out", 32'(e & m), 32'(attr & m));
            mpd_core_model_i.access(1'b1, 1'b0, 1'b0, 32'h80, r);
            chk("attr access", 32'h4, 32'(r));
        end
    endtask

    task automatic t_regs();
        bus(1'b1, OFS_ATTR, 32'hFFFF_FFFF);
        bus(1'b0, OFS_ATTR, '0);
        chk("attr mask", ATTR_MASK, q);
        bus(1'b1, 4'h0, 32'h0003_0000);
        bus(1'b1, OFS_DECODE, 32'hFFFF_FFFF);
        bus(1'b0, OFS_DECODE, '0);
        chk("decode ro", 32'h0000_0052, q);
        hsel   <= 1'b1;
        haddr  <= 32'h0000_0010;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        chk("unmapped", 32'h0, hrdata);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_perm();
        t_fstat();
        t_attr();
        t_regs();
        report_and_stop();
    end
endmodule
